// File: hw/brl_blink.sv
// Square-wave blink generator advanced by the slow tick.
module brl_blink #(
  parameter int unsigned HALF_TICKS = 100
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Timing
  input  wire logic tick,
  // Output phase
  output logic      phase
);
  logic [brl_pkg::BLINK_W-1:0] count;
  wire last = (count == brl_pkg::BLINK_W'(HALF_TICKS - 1));
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count <= '0;
      phase <= 1'b0;
    end else if (tick) begin
      count <= last ? '0 : count + 1'b1;
      if (last) phase <= ~phase;
    end
  end
endmodule // brl_blink

// File: hw/brl_pkg.sv
// Shared constants for the button reset and status indicator block.
package brl_pkg;
  localparam int unsigned CLOCK_HZ      = 250_000_000;
  localparam int unsigned TICK_HZ       = 1000;
  // Prescaler count for one slow tick (1 ms at the system rate).
  localparam int unsigned TICK_CYCLES   = CLOCK_HZ / TICK_HZ;
  localparam int unsigned WARN_TIME_S   = 9;
  localparam int unsigned RESTORE_TIME_S = 12;
  localparam int unsigned WARN_TICKS    = WARN_TIME_S * TICK_HZ;
  localparam int unsigned RESTORE_TICKS = RESTORE_TIME_S * TICK_HZ;
  // Blink half periods in ticks: fault warning slow, activity faster.
  localparam int unsigned WARN_HALF_TICKS = 100;
  localparam int unsigned ACT_HALF_TICKS  = 50;
  localparam int unsigned HOLD_W        = 16;
  localparam int unsigned BLINK_W       = 8;
  localparam int unsigned FAULT_W       = 8;
  // Cycles the restore and restart pulses stand.
  localparam int unsigned PULSE_CYCLES  = 1;
endpackage : brl_pkg

// File: hw/brl_top.sv
// Reset button supervision and front panel indicator drive.
module brl_top #(
  parameter int unsigned COPPER_PORTS  = 13,
  parameter int unsigned FIBRE_PORTS   = 3,
  parameter int unsigned TICK_CYCLES   = brl_pkg::TICK_CYCLES,
  parameter int unsigned WARN_TICKS    = brl_pkg::WARN_TICKS,
  parameter int unsigned RESTORE_TICKS = brl_pkg::RESTORE_TICKS
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  // Push button pin, active low, asynchronous
  input  wire logic                          button_n,
  // Settings from management software
  input  wire logic                          button_enable,
  input  wire logic [brl_pkg::FAULT_W-1:0]   fault_select,
  // Internal status
  input  wire logic                          powered,
  input  wire logic                          undervoltage,
  input  wire logic [brl_pkg::FAULT_W-1:0]   fault_events,
  input  wire logic [COPPER_PORTS-1:0]       copper_link,
  input  wire logic [COPPER_PORTS-1:0]       copper_rx,
  input  wire logic [FIBRE_PORTS-1:0]        fibre_link,
  input  wire logic [FIBRE_PORTS-1:0]        fibre_rx,
  // System requests
  output logic                               restore_defaults,
  output logic                               restart,
  // Indicators
  output logic                               fault_green,
  output logic                               fault_red,
  output logic [COPPER_PORTS-1:0]            copper_link_led,
  output logic [COPPER_PORTS-1:0]            copper_rx_led,
  output logic [FIBRE_PORTS-1:0]             fibre_led
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_HOLD, ST_WARN, ST_ARMED, ST_RESTORE, ST_RESTART
  } brl_state_t;

  brl_state_t state;
  brl_state_t next_state;

  // Button synchroniser; only the second stage is read.
  logic btn_meta;
  logic btn_sync;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      btn_meta <= 1'b1;
      btn_sync <= 1'b1;
    end else begin
      btn_meta <= button_n;
      btn_sync <= btn_meta;
    end
  end
  wire pressed = ~btn_sync;

  // Slow tick prescaler.
  localparam int unsigned PRE_W = $clog2(TICK_CYCLES + 1);
  logic [PRE_W-1:0] pre;
  wire tick = (pre == PRE_W'(TICK_CYCLES - 1));
  always_ff @(posedge clock) begin
    if (!reset_n) pre <= '0;
    else pre <= tick ? '0 : pre + 1'b1;
  end

  logic warn_phase;
  logic act_phase;
  brl_blink #(.HALF_TICKS(brl_pkg::WARN_HALF_TICKS)) u_warn_blink (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (tick),
    .phase   (warn_phase)
  );
  brl_blink #(.HALF_TICKS(brl_pkg::ACT_HALF_TICKS)) u_act_blink (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (tick),
    .phase   (act_phase)
  );

  // Hold time counter, counts ticks while the button is down in the hold and warning states.
  logic [brl_pkg::HOLD_W-1:0] held;
  wire reach_warn    = (held >= brl_pkg::HOLD_W'(WARN_TICKS));
  wire reach_restore = (held >= brl_pkg::HOLD_W'(RESTORE_TICKS));
  wire counting = (state == ST_HOLD) || (state == ST_WARN);
  always_ff @(posedge clock) begin
    if (!reset_n) held <= '0;
    else if (!counting) held <= '0;
    else if (tick && !reach_restore) held <= held + 1'b1;
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (pressed && button_enable) next_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (!button_enable || !pressed) next_state = ST_IDLE;
        else if (reach_warn) next_state = ST_WARN;
      end
      ST_WARN: begin
        if (!button_enable || !pressed) next_state = ST_IDLE;
        else if (reach_restore) next_state = ST_ARMED;
      end
      ST_ARMED: begin
        if (!button_enable) next_state = ST_IDLE;
        else if (!pressed) next_state = ST_RESTORE;
      end
      ST_RESTORE: next_state = ST_RESTART;
      ST_RESTART: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) state <= ST_IDLE;
    else state <= next_state;
  end

  // Fault detection with software selection.
  wire problem = undervoltage | |(fault_events & fault_select);
  wire warning = (state == ST_WARN);
  wire next_red   = powered & (warning ? warn_phase : problem);
  wire next_green = powered & ~warning & ~problem;

  wire [COPPER_PORTS-1:0] next_cu_link = copper_link;
  wire [COPPER_PORTS-1:0] next_cu_rx =
    copper_rx & {COPPER_PORTS{act_phase}};
  wire [FIBRE_PORTS-1:0] next_fibre = fibre_link & fibre_rx;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      restore_defaults <= 1'b0;
      restart          <= 1'b0;
      fault_green      <= 1'b0;
      fault_red        <= 1'b0;
      copper_link_led  <= '0;
      copper_rx_led    <= '0;
      fibre_led        <= '0;
    end else begin
      restore_defaults <= (next_state == ST_RESTORE);
      restart          <= (next_state == ST_RESTART);
      fault_green      <= next_green;
      fault_red        <= next_red;
      copper_link_led  <= next_cu_link;
      copper_rx_led    <= next_cu_rx;
      fibre_led        <= next_fibre;
    end
  end
endmodule // brl_top

// File: tb/brl_operator.sv
// Model of the operator who presses the rear push button.
module brl_operator (
  // Request from the bench
  input  wire logic pressed,
  // Button pin, low while pressed
  output logic      button_n
);
  timeunit 1ns;
  timeprecision 1ps;
  assign button_n = !pressed;
endmodule // brl_operator

// File: tb/brl_top_asserts.sv
// Concurrent checks on the ports of the button and indicator block.
module brl_top_asserts #(
  parameter int unsigned COPPER_PORTS = 13,
  parameter int unsigned FIBRE_PORTS  = 3
) (
  // Single-bit ports
  input wire logic clock, reset_n, button_n, button_enable, powered,
  input wire logic undervoltage, restore_defaults, restart,
  input wire logic fault_green, fault_red,
  // Fault and port status
  input wire logic [brl_pkg::FAULT_W-1:0] fault_select, fault_events,
  input wire logic [COPPER_PORTS-1:0] copper_link, copper_rx,
  input wire logic [COPPER_PORTS-1:0] copper_link_led, copper_rx_led,
  input wire logic [FIBRE_PORTS-1:0] fibre_link, fibre_rx, fibre_led
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic ok = powered && !undervoltage &&
                  !(|(fault_events & fault_select));
  pulse_pair_a: assert property (
    restore_defaults |=> restart && !restore_defaults)
    else $error("restart did not follow restore");
  restart_src_a: assert property (restart |-> $past(restore_defaults))
    else $error("restart without restore");
  after_release_a: assert property (
    restore_defaults |-> $past(button_n, 2) && !$past(button_n, 5))
    else $error("restore not tied to a release");
  enable_off_a: assert property (!button_enable[*4] |=> !restore_defaults)
    else $error("restore while button disabled");
  dark_off_a: assert property (!powered |=> !fault_green && !fault_red)
    else $error("fault led lit while off");
  green_ok_a: assert property (
    button_n[*5] ##0 ok |=> fault_green && !fault_red)
    else $error("fault led not green");
  red_fault_a: assert property (
    button_n[*5] ##0 (powered && !ok) |=> fault_red && !fault_green)
    else $error("fault led not red");
  port_leds_a: assert property (
    $past(reset_n) |-> copper_link_led == $past(copper_link) &&
    fibre_led == $past(fibre_link & fibre_rx))
    else $error("link led mismatch");
  rx_dark_a: assert property (
    $past(reset_n) |-> (copper_rx_led & ~$past(copper_rx)) == '0)
    else $error("rx led lit without data");
  cover property (restore_defaults);
  cover property (!button_n[*8] ##1 button_n);
  cover property ($rose(copper_rx_led[0]));
endmodule // brl_top_asserts
bind brl_top brl_top_asserts #(.COPPER_PORTS(COPPER_PORTS),
  .FIBRE_PORTS(FIBRE_PORTS)) u_brl_top_asserts (.*);

// File: tb/brl_top_tb.sv
// Self-checking bench for the button reset and indicator block.
module brl_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, reset_n = 0, pressed = 0, button_enable = 1, button_n;
  logic powered = 1, undervoltage = 0, restore_defaults, restart;
  logic fault_green, fault_red;
  logic [7:0] fault_select = 8'hff, fault_events = 8'h00;
  logic [12:0] copper_link = 13'h0000, copper_rx = 13'h0000;
  logic [12:0] copper_link_led, copper_rx_led;
  logic [2:0] fibre_link = 3'h0, fibre_rx = 3'h0, fibre_led;
  int n_fail = 0, total_checks = 0, seen;
  // Rows hold {power, undervoltage}, events, select, {green, red}.
  logic [23:0] rows [5] = '{24'h000000, 24'h200ff2, 24'h300001,
                           24'h20ff02, 24'h210f01};
  // The warning window spans more than one warning blink half period.
  brl_top #(.TICK_CYCLES(8), .WARN_TICKS(9), .RESTORE_TICKS(120))
    u_brl_top (.*);
  brl_operator u_brl_operator (.pressed(pressed), .button_n(button_n));
  initial forever #2 clock = ~clock;
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Holds the button n cycles, then watches ten cycles for a restore.
  task automatic hold(input int n, input logic want);
    pressed <= 1;
    cyc(n);
    pressed <= 0;
    seen = 0;
    repeat (10) begin
      cyc(1);
      seen |= int'(restore_defaults === 1'b1);
    end
    chk(seen == int'(want), "restore pulse");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    cyc(16);
    chk({fault_green, fault_red, restore_defaults} === 3'h0, "reset");
    reset_n <= 1;
    fibre_link <= 3'h5;
    fibre_rx <= 3'h3;
    cyc(2);
    foreach (rows[i]) begin
      {powered, undervoltage} <= rows[i][21:20];
      fault_events <= rows[i][19:12];
      fault_select <= rows[i][11:4];
      copper_link <= {13{i[0]}};
      cyc(3);
      chk({fault_green, fault_red} === rows[i][1:0], "fault led");
      chk(copper_link_led === {13{i[0]}} && fibre_led === 3'h1, "port");
    end
    fault_events <= 8'h00;
    pressed <= 1;
    cyc(90);
    chk(fault_green === 1'b0, "green in warning");
    seen = 0;
    repeat (850) begin
      cyc(1);
      seen |= (fault_red === 1'b1) ? 2 : 1;
    end
    chk(seen == 3, "red not flashing in warning");
    cyc(40);
    chk(fault_green === 1'b1, "armed display");
    hold(1, 1'b1);
    hold(60, 1'b0);
    hold(90, 1'b0);
    button_enable <= 0;
    hold(130, 1'b0);
    // A reset while armed must discard the pending restore.
    button_enable <= 1;
    pressed <= 1;
    cyc(1000);
    reset_n <= 0;
    cyc(2);
    chk({fault_green, restore_defaults} === 2'h0, "mid reset");
    reset_n <= 1;
    hold(1, 1'b0);
    copper_rx <= 13'h1fff;
    seen = 0;
    repeat (900) begin
      cyc(1);
      seen |= (copper_rx_led[3] === 1'b1) ? 2 : 1;
    end
    chk(seen == 3, "rx led not flashing");
    stop_test;
  end
endmodule // brl_top_tb
